// File: bench/rsq_board_model.sv
// Board model: reset source, DRAM reset enable, strap and interrupt pins.
`timescale 1ns/10ps
module rsq_board_model #(
  parameter int IRQ_W = 7
) (
  input wire logic mclk,
  input wire logic reset_out_n,
  output logic ext_reset_in_n,
  output logic dram_reset_enable_n,
  output rsq_pkg::rsq_straps_t straps,
  output logic [IRQ_W-1:0] ext_irq_inputs_n
);
  import rsq_pkg::*;
  rsq_straps_t lvl = 4'h0;
  logic [IRQ_W-1:0] irq_lvl = '1;
  logic [7:0] noise = 8'h00;
  // ****************
  // Pins
  // ****************
  // Once the device runs, the shared pins carry unrelated traffic.
  assign straps = reset_out_n ? (lvl ^ noise[3:0]) : lvl;
  assign ext_irq_inputs_n = reset_out_n ? noise[IRQ_W-1:0] : irq_lvl;
  always @(negedge mclk) begin
    noise <= noise + 8'h01;
  end
  // Power-on asserts both lines together.
  initial begin
    ext_reset_in_n = 1'b0;
    dram_reset_enable_n = 1'b0;
  end
  // Holds never drop below the minimum, so short requests are stretched.
  task automatic pulse(input logic por, input rsq_straps_t s,
      input logic [IRQ_W-1:0] irq, input int len);
    @(negedge mclk);
    lvl <= s;
    irq_lvl <= irq;
    ext_reset_in_n <= 1'b0;
    dram_reset_enable_n <= ~por;
    repeat ((len < RSQ_MIN_RESET_CYCLES) ? RSQ_MIN_RESET_CYCLES : len)
      @(negedge mclk);
    ext_reset_in_n <= 1'b1;
    dram_reset_enable_n <= 1'b1;
  endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the reset sequencer and mode latch.
`timescale 1ns/10ps
`define CHK(a, e) begin \
  tests_run++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
  end \
end
module tb;
  import rsq_pkg::*;
  localparam int STR = 16;
  localparam int IW = 7;
  logic mclk = 1'b0;
  logic sys_rst;
  logic core_first_cycle;
  logic ext_reset_in_n;
  logic dram_reset_enable_n;
  rsq_straps_t straps;
  logic [IW-1:0] irq_n;
  logic reset_out_n;
  rsq_mode_t mode;
  logic sdram_preserve;
  logic [IW-1:0] irq_snap;
  logic bus_hold_default;
  int failures;
  int tests_run;
  always #2.5 mclk = ~mclk;
  rsq_reset_sequencer #(.STRETCH(STR), .IRQ_W(IW)) dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .ext_reset_in_n(ext_reset_in_n),
    .dram_reset_enable_n(dram_reset_enable_n), .straps(straps),
    .ext_irq_inputs_n(irq_n), .core_first_cycle(core_first_cycle),
    .reset_out_n(reset_out_n), .mode(mode),
    .sdram_preserve(sdram_preserve), .irq_reset_snapshot(irq_snap),
    .bus_hold_default(bus_hold_default));
  rsq_board_model #(.IRQ_W(IW)) src_u (
    .mclk(mclk), .reset_out_n(reset_out_n),
    .ext_reset_in_n(ext_reset_in_n),
    .dram_reset_enable_n(dram_reset_enable_n), .straps(straps),
    .ext_irq_inputs_n(irq_n));
  // ****************
  // Tasks
  // ****************
  function automatic rsq_mode_t exp_mode(input logic [3:0] s);
    rsq_mode_t m;
    m.bus32 = ~s[3];
    m.boot32 = s[2:1] == 2'h0;
    m.boot16 = s[2:1] == 2'h2;
    m.boot8 = s[2:1] == 2'h1;
    m.float_all_pins = ~s[0];
    m.boot_reserved = s[2:1] == 2'h3;
    return m;
  endfunction
  // The release lands on a falling edge, so two cycles of slack are allowed.
  task automatic run_case(input logic por, input logic [3:0] s,
      input logic [IW-1:0] irq, input logic again);
    int n;
    rsq_mode_t em;
    n = 0;
    em = exp_mode(s);
    src_u.pulse(por, s, irq, 8);
    if (again) begin
      repeat (8) @(negedge mclk);
      `CHK(reset_out_n, 1'b0)
      src_u.pulse(por, s, irq, STR + 4);
    end
    `CHK({reset_out_n, bus_hold_default}, 2'h1)
    while (reset_out_n !== 1'b1 && n < 4 * STR) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(n >= STR + 1 && n <= STR + 3, 1'b1)
    `CHK(mode, em)
    `CHK(sdram_preserve, ~por)
    `CHK(irq_snap, ~irq)
    repeat (4) @(negedge mclk);
    `CHK(mode, em)
    `CHK(bus_hold_default, 1'b1)
    core_first_cycle = 1'b1;
    @(negedge mclk);
    core_first_cycle = 1'b0;
    `CHK(bus_hold_default, 1'b0)
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    failures = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    core_first_cycle = 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      run_case(i == 0 || i[2], i[3:0], IW'(i * 37), i == 5);
      $display("test %0d done", i);
    end
    final_report();
  end
  // Sixteen cases (seventeen resets) need about 3 us; seven times that means a hang.
  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule

// File: hdl/rsq_pkg.sv
// Package with constants and types for the reset sequencer and mode latch.
package rsq_pkg;

  // ********************************
  // Timing
  // ********************************
  localparam int RSQ_STRETCH_CYCLES = 32768;
  localparam int RSQ_MIN_RESET_CYCLES = 6;
  localparam logic [15:0] RSQ_CNT_RESET = 16'h0000;

  // ********************************
  // Mode encodings
  // ********************************
  localparam logic RSQ_BUS_WIDTH_SELECT_32 = 1'b0;
  localparam logic [1:0] RSQ_BOOT_32 = 2'h0;
  localparam logic [1:0] RSQ_BOOT_8 = 2'h1;
  localparam logic [1:0] RSQ_BOOT_16 = 2'h2;
  localparam logic [1:0] RSQ_BOOT_RSV = 2'h3;
  localparam logic RSQ_FLOAT_ACTIVE = 1'b0;

  // Reset values of the latched modes: 32-bit bus, 32-bit boot, no float.
  localparam logic RSQ_RST_WIDE32 = 1'b1;
  localparam logic [2:0] RSQ_RST_BOOT = 3'h4;
  localparam logic RSQ_RST_FLOAT = 1'b0;

  typedef enum logic [1:0] {
    RSQ_HOLD = 2'b00,
    RSQ_STRETCH = 2'b01,
    RSQ_RUN = 2'b11
  } rsq_state_t;

  typedef struct packed {
    logic bus_width_select;
    logic boot_port_width_hi;
    logic boot_port_width_lo;
    logic float_all_pins_in;
  } rsq_straps_t;

  // Decoded modes: bus width, float, and one-hot boot port width: 32, 16, 8 bits or reserved.
  typedef struct packed {
    logic bus32;
    logic boot32;
    logic boot16;
    logic boot8;
    logic float_all_pins;
    logic boot_reserved;
  } rsq_mode_t;

endpackage

// File: hdl/rsq_reset_sequencer.sv
// Reset sequencer that stretches reset and latches boot mode straps.
`timescale 1ns/10ps
module rsq_reset_sequencer #(
  parameter int STRETCH = rsq_pkg::RSQ_STRETCH_CYCLES,
  parameter int IRQ_W = 7
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ext_reset_in_n,
  input wire logic dram_reset_enable_n,
  input wire rsq_pkg::rsq_straps_t straps,
  input wire logic [IRQ_W-1:0] ext_irq_inputs_n,
  input wire logic core_first_cycle,
  output logic reset_out_n,
  output rsq_pkg::rsq_mode_t mode,
  output logic sdram_preserve,
  output logic [IRQ_W-1:0] irq_reset_snapshot,
  output logic bus_hold_default
);
  import rsq_pkg::*;

  // ********************************
  // Input synchronisers
  // ********************************
  logic rst_s;
  logic dre_s;
  logic [1:0] rst_dre_s;
  logic [IRQ_W-1:0] irq_s;
  logic [3:0] straps_s;

  rsq_sync #(.W(2), .INIT(2'h3)) u_rst_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({~ext_reset_in_n, ~dram_reset_enable_n}),
    .sync_out(rst_dre_s)
  );
  assign rst_s = rst_dre_s[1];
  assign dre_s = rst_dre_s[0];

  rsq_sync #(.W(IRQ_W), .INIT('0)) u_irq_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(~ext_irq_inputs_n),
    .sync_out(irq_s)
  );

  rsq_sync #(.W(4), .INIT(4'h0)) u_strap_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(straps),
    .sync_out(straps_s)
  );

  // ********************************
  // Sequencer
  // ********************************
  rsq_state_t st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic reset_out_q, reset_out_d;
  logic rst_out_n_q, rst_out_n_d;
  logic keep_q, keep_d;
  logic hold_q, hold_d;
  logic [IRQ_W-1:0] irq_q, irq_d;
  rsq_mode_t mode_q, mode_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    reset_out_d = reset_out_q;
    keep_d = keep_q;
    hold_d = hold_q;
    irq_d = irq_q;
    mode_d = mode_q;
    unique case (st_q)
      RSQ_HOLD: begin
        reset_out_d = 1'b1;
        hold_d = 1'b1;
        // Only samples seen with reset still asserted count, so a power-on
        // reset that drops both lines together is not taken as normal.
        if (rst_s) begin
          keep_d = ~dre_s;
          irq_d = irq_s;
        end
        cnt_d = RSQ_CNT_RESET;
        if (!rst_s) begin
          st_d = RSQ_STRETCH;
        end
      end
      RSQ_STRETCH: begin
        if (rst_s) begin
          st_d = RSQ_HOLD;
        end else if (cnt_q == 16'(STRETCH - 1)) begin
          st_d = RSQ_RUN;
          reset_out_d = 1'b0;
          mode_d.bus32 = (straps_s[3] == RSQ_BUS_WIDTH_SELECT_32);
          mode_d.boot32 = (straps_s[2:1] == RSQ_BOOT_32);
          mode_d.boot8 = (straps_s[2:1] == RSQ_BOOT_8);
          mode_d.boot16 = (straps_s[2:1] == RSQ_BOOT_16);
          mode_d.boot_reserved = (straps_s[2:1] == RSQ_BOOT_RSV);
          mode_d.float_all_pins = (straps_s[0] == RSQ_FLOAT_ACTIVE);
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      RSQ_RUN: begin
        // modes hold here until a new reset.
        if (core_first_cycle) begin
          hold_d = 1'b0;
        end
        if (rst_s) begin
          st_d = RSQ_HOLD;
          reset_out_d = 1'b1;
          hold_d = 1'b1;
        end
      end
      default: begin
        st_d = RSQ_HOLD;
      end
    endcase
    rst_out_n_d = ~reset_out_d;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= RSQ_HOLD;
      cnt_q <= RSQ_CNT_RESET;
      reset_out_q <= 1'b1;
      rst_out_n_q <= 1'b0;
      keep_q <= 1'b0;
      hold_q <= 1'b1;
      irq_q <= '0;
      mode_q <= {RSQ_RST_WIDE32, RSQ_RST_BOOT, RSQ_RST_FLOAT, 1'b0};
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      reset_out_q <= reset_out_d;
      rst_out_n_q <= rst_out_n_d;
      keep_q <= keep_d;
      hold_q <= hold_d;
      irq_q <= irq_d;
      mode_q <= mode_d;
    end
  end

  assign reset_out_n = rst_out_n_q;
  assign mode = mode_q;
  assign sdram_preserve = keep_q;
  assign irq_reset_snapshot = irq_q;
  assign bus_hold_default = hold_q;

  // ********************************
  // Checks
  // ********************************
  logic [16:0] run_cnt_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      run_cnt_q <= '0;
    end else if (!reset_out_q || rst_s) begin
      run_cnt_q <= '0;
    end else if (run_cnt_q != 17'h1ffff) begin
      run_cnt_q <= run_cnt_q + 17'h00001;
    end
  end

  property p_reset_follows;
    @(posedge mclk) disable iff (sys_rst)
      rst_s |=> reset_out_q;
  endproperty
  a_reset_follows: assert property (p_reset_follows)
    else $error("reset output dropped while reset input asserted");

  property p_stretch_len;
    @(posedge mclk) disable iff (sys_rst)
      $fell(reset_out_q) |-> run_cnt_q == 17'(STRETCH + 1);
  endproperty
  a_stretch_len: assert property (p_stretch_len)
    else $error("reset stretch length wrong");

  property p_mode_bus;
    @(posedge mclk) disable iff (sys_rst)
      $fell(reset_out_q) |-> mode_q.bus32 == ($past(straps_s[3]) == 1'b0);
  endproperty
  a_mode_bus: assert property (p_mode_bus)
    else $error("bus width not taken from strap");

  property p_mode_boot;
    @(posedge mclk) disable iff (sys_rst)
      $fell(reset_out_q) |-> mode_q.boot8 == ($past(straps_s[2:1]) == 2'h1)
        && mode_q.boot16 == ($past(straps_s[2:1]) == 2'h2);
  endproperty
  a_mode_boot: assert property (p_mode_boot)
    else $error("boot width not taken from straps");

  property p_mode_float;
    @(posedge mclk) disable iff (sys_rst)
      $fell(reset_out_q) |-> mode_q.float_all_pins == !$past(straps_s[0]);
  endproperty
  a_mode_float: assert property (p_mode_float)
    else $error("float mode not taken from strap");

  property p_mode_stable;
    @(posedge mclk) disable iff (sys_rst)
      !reset_out_q && !$past(reset_out_q) |-> $stable(mode_q);
  endproperty
  a_mode_stable: assert property (p_mode_stable)
    else $error("latched mode changed after capture");

  property p_keep;
    @(posedge mclk) disable iff (sys_rst)
      rst_s && st_q == RSQ_HOLD |=> keep_q == !$past(dre_s);
  endproperty
  a_keep: assert property (p_keep)
    else $error("sdram preserve flag wrong");

  property p_irq;
    @(posedge mclk) disable iff (sys_rst)
      rst_s && st_q == RSQ_HOLD |=> irq_q == $past(irq_s);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq snapshot not taken during reset");

  property p_hold;
    @(posedge mclk) disable iff (sys_rst)
      reset_out_q |-> hold_q;
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus released during reset");

endmodule

// File: hdl/rsq_sync.sv
// Two-stage synchroniser, falling edge then rising edge of the clock.
`timescale 1ns/10ps
module rsq_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The falling stage gives half a period to settle; faster than two full
  // cycles but matches the documented recognition edge.
  always_ff @(negedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= INIT;
    end else begin
      meta_q <= async_in;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_q <= INIT;
    end else begin
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule
